// ### verilog/nvi_core.sv
// Interrupt acceptance, priority masking, context save and return sequencing
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - Identifiers 1 and 2 take a selected source
// - Pending latch held until accept, reset, clear
// - Source condition sets its pending latch
// - Accept needs own and master enable; clears
// - Accept blocks lower priority sources
// - Entry decrements both stack pointers
// - Entry pushes PC and context words
// - Saved address is the following address
// - Entry loads vector into program counter
// - Whole entry in one interrupt cycle
// - Return re-enables lower priority sources
// - Return restores context and program counter
// - Return increments both stack pointers
// - Whole return in one instruction cycle
// - Accept regardless of executing code; a return instruction defers it
// - Same or lower refused, higher accepted
// - External pins raise on chosen edges
// - Vectors 0001H to 0004H per identifier
// - On and off instructions steer master
// - Reset priority follows identifier order
// - Latches readable, software clear cancels
module nvi_core (
    // Clock and reset
    input  wire logic                         i_clk,
    input  wire logic                         i_rst,
    // External request pins and their edge choice
    input  wire logic                         i_ext_request_pin_a,
    input  wire logic                         i_ext_request_pin_b,
    input  wire logic [1:0]                   i_edge_sel_a,
    input  wire logic [1:0]                   i_edge_sel_b,
    // Internal peripheral request pulses
    input  wire logic                         i_timer_port_req,
    input  wire logic                         i_serial_req,
    input  wire logic                         i_lowvolt_req,
    input  wire logic                         i_timer_cnt_req,
    // Source selection for identifiers 1 and 2
    input  wire logic                         i_src1_sel,
    input  wire logic [1:0]                   i_src2_sel,
    // Enables and master control instructions
    input  wire logic [nvi_pkg::N_ID-1:0]     i_irq_enable,
    input  wire logic                         i_master_irq_on_instr,
    input  wire logic                         i_master_irq_off_instr,
    // Pending latch access
    input  wire logic [nvi_pkg::N_ID-1:0]     i_latch_clr,
    output logic      [nvi_pkg::N_ID-1:0]     o_latch,
    output logic                              o_master_en,
    // Priority table write
    input  wire logic                         i_prio_wr,
    input  wire nvi_pkg::nvi_prio_s           i_prio_data,
    output nvi_pkg::nvi_prio_s                o_prio,
    // Core sequencer side
    input  wire logic                         i_boundary,
    input  wire logic                         i_return_from_irq_instr,
    input  wire logic [nvi_pkg::PC_W-1:0]     i_pc_next,
    input  wire nvi_pkg::nvi_ctx_s            i_ctx,
    output logic                              o_entry,
    output logic                              o_return,
    output logic      [nvi_pkg::PC_W-1:0]     o_pc_load,
    output nvi_pkg::nvi_ctx_s                 o_ctx,
    output logic      [nvi_pkg::ID_W-1:0]     o_active_id,
    output logic      [nvi_pkg::N_ID-1:0]     o_in_service,
    // Stack pointers
    output logic      [nvi_pkg::RS_PTR_W-1:0] o_return_stack_pointer,
    output logic      [nvi_pkg::CS_PTR_W-1:0] o_context_stack_pointer
);
    import nvi_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Helper functions

    // Lowest set bit of a level mask, as index
    function automatic logic [ID_W-1:0] first_set(input logic [N_ID-1:0] m);
        logic [ID_W-1:0] idx;
        idx = 2'h0;
        for (int k = N_ID - 1; k >= 0; k--) begin
            if (m[k]) begin
                idx = k[ID_W-1:0];
            end
        end
        return idx;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Request sources

    logic pin_a_req;
    logic pin_b_req;
    logic [N_ID-1:0] src_req;

    // Pins cross into the clock domain inside the edge blocks
    // selectable edges
    nvi_pin_edge u_edge_a (
        .i_clk      (i_clk),
        .i_rst      (i_rst),
        .i_pin      (i_ext_request_pin_a),
        .i_edge_sel (i_edge_sel_a),
        .o_req      (pin_a_req)
    );

    nvi_pin_edge u_edge_b (
        .i_clk      (i_clk),
        .i_rst      (i_rst),
        .i_pin      (i_ext_request_pin_b),
        .i_edge_sel (i_edge_sel_b),
        .o_req      (pin_b_req)
    );

    // Shared identifiers pick one source; an unused code feeds nothing
    // shared identifier routing
    always_comb begin
        src_req[0] = pin_a_req;
        src_req[1] = (i_src1_sel == SRC1_PIN_B) ? pin_b_req : i_timer_port_req;
        unique case (i_src2_sel)
            SRC2_SERIAL: src_req[2] = i_serial_req;
            SRC2_TPORT:  src_req[2] = i_timer_port_req;
            SRC2_LOWV:   src_req[2] = i_lowvolt_req;
            default:     src_req[2] = 1'b0;
        endcase
        src_req[3] = i_timer_cnt_req;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Arbitration

    nvi_state_e state_r;
    nvi_state_e state_nxt;
    logic [N_ID-1:0] latch_r;
    logic [N_ID-1:0] latch_nxt;
    logic [N_ID-1:0] isr_r;
    logic [N_ID-1:0] isr_nxt;
    logic            master_r;
    logic            master_nxt;
    nvi_prio_s       prio_r;
    nvi_prio_s       prio_nxt;
    logic [N_ID-1:0] cand_lvl;
    logic [N_ID-1:0] isr_block;
    logic [ID_W-1:0] win_lvl;
    logic [ID_W-1:0] win_id;
    logic            accept;
    logic            do_return;

    // Candidates by level; lowest slot wins
    // both enables needed
    always_comb begin
        for (int k = 0; k < N_ID; k++) begin
            cand_lvl[k] = latch_r[prio_r.lvl_id[k]] & i_irq_enable[prio_r.lvl_id[k]];
        end
        cand_lvl = master_r ? cand_lvl : '0;
    end

    // A level in service blocks itself and every less urgent level
    // same or lower refused
    always_comb begin
        isr_block[0] = isr_r[0];
        for (int k = 1; k < N_ID; k++) begin
            isr_block[k] = isr_block[k-1] | isr_r[k];
        end
    end

    // Most urgent unblocked candidate, at a boundary
    // highest level first
    always_comb begin
        win_lvl   = first_set(cand_lvl & ~isr_block);
        win_id    = prio_r.lvl_id[win_lvl];
        do_return = i_return_from_irq_instr && (state_r == NVI_IDLE);
        accept    = i_boundary && !do_return && (state_r == NVI_IDLE)
                    && |(cand_lvl & ~isr_block);
    end

    ////////////////////////////////////////////////////////////////////////////
    // Control state next values

    // Latch: new event wins over both accept and software clear
    // event sets latch
    always_comb begin
        latch_nxt = latch_r & ~i_latch_clr;
        if (accept) begin
            latch_nxt[win_id] = 1'b0;
        end
        latch_nxt = latch_nxt | src_req;
    end

    // Master flag moves only on the on/off instructions
    // master flag control
    always_comb begin
        master_nxt = master_r;
        if (i_master_irq_on_instr) begin
            master_nxt = 1'b1;
        end else if (i_master_irq_off_instr) begin
            master_nxt = 1'b0;
        end
    end

    // In-service mask; the active level is always the most urgent one set
    always_comb begin
        isr_nxt = isr_r;
        if (accept) begin
            isr_nxt[win_lvl] = 1'b1;
        end else if (do_return) begin
            isr_nxt[first_set(isr_r)] = 1'b0;
        end
    end

    // Priority table only changes on an explicit write
    always_comb begin
        prio_nxt = i_prio_wr ? i_prio_data : prio_r;
    end

    // Sequencer: outputs stand one cycle
    // single entry cycle
    always_comb begin
        state_nxt = NVI_IDLE;
        if (accept) begin
            state_nxt = NVI_ENTER;
        end else if (do_return) begin
            state_nxt = NVI_RETURN;
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            state_r  <= NVI_IDLE;
            latch_r  <= LATCH_RST;
            isr_r    <= ISR_RST;
            master_r <= MASTER_RST;
            prio_r   <= PRIO_RST;
        end else begin
            state_r  <= state_nxt;
            latch_r  <= latch_nxt;
            isr_r    <= isr_nxt;
            master_r <= master_nxt;
            prio_r   <= prio_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Stacks and pointers

    logic [RS_PTR_W-1:0] rs_ptr_r;
    logic [RS_PTR_W-1:0] rs_ptr_nxt;
    logic [CS_PTR_W-1:0] cs_ptr_r;
    logic [CS_PTR_W-1:0] cs_ptr_nxt;
    logic [PC_W-1:0]     rs_rdata;
    logic [CTX_W-1:0]    cs_rdata;
    logic [PC_W-1:0]     vec_r;
    logic [PC_W-1:0]     vec_nxt;
    logic [ID_W-1:0]     id_r;
    logic [ID_W-1:0]     id_nxt;

    // Pointers wrap silently; overrunning the depth is a software fault
    always_comb begin
        rs_ptr_nxt = rs_ptr_r;
        cs_ptr_nxt = cs_ptr_r;
        if (accept) begin
            rs_ptr_nxt = rs_ptr_r - 4'h1;
            cs_ptr_nxt = cs_ptr_r - 2'h1;
        end else if (do_return) begin
            rs_ptr_nxt = rs_ptr_r + 4'h1;
            cs_ptr_nxt = cs_ptr_r + 2'h1;
        end
    end

    // Vector and identifier captured with the accept
    // vector per identifier
    always_comb begin
        vec_nxt = accept ? VEC_TABLE[win_id] : vec_r;
        id_nxt  = accept ? win_id : id_r;
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            rs_ptr_r <= RS_PTR_RST;
            cs_ptr_r <= CS_PTR_RST;
            vec_r    <= '0;
            id_r     <= '0;
        end else begin
            rs_ptr_r <= rs_ptr_nxt;
            cs_ptr_r <= cs_ptr_nxt;
            vec_r    <= vec_nxt;
            id_r     <= id_nxt;
        end
    end

    // Push writes at the decremented slot; pop reads the current slot
    // push PC and context
    nvi_stack_mem #(
        .W  (PC_W),
        .D  (RS_DEPTH),
        .AW (RS_PTR_W)
    ) u_return_stack (
        .i_clk   (i_clk),
        .i_we    (accept),
        .i_waddr (rs_ptr_nxt),
        .i_wdata (i_pc_next),
        .i_re    (do_return),
        .i_raddr (rs_ptr_r),
        .o_rdata (rs_rdata)
    );

    nvi_stack_mem #(
        .W  (CTX_W),
        .D  (CS_DEPTH),
        .AW (CS_PTR_W)
    ) u_context_stack (
        .i_clk   (i_clk),
        .i_we    (accept),
        .i_waddr (cs_ptr_nxt),
        .i_wdata (i_ctx),
        .i_re    (do_return),
        .i_raddr (cs_ptr_r),
        .o_rdata (cs_rdata)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Outputs

    // Core loads the vector on entry, the popped address on return
    // vector load
    always_comb begin
        o_entry   = (state_r == NVI_ENTER);
        o_return  = (state_r == NVI_RETURN);
        o_pc_load = (state_r == NVI_RETURN) ? rs_rdata : vec_r;
        o_ctx     = nvi_ctx_s'(cs_rdata);
    end

    assign o_latch                 = latch_r;
    assign o_master_en             = master_r;
    assign o_prio                  = prio_r;
    assign o_active_id             = id_r;
    assign o_in_service            = isr_r;
    assign o_return_stack_pointer  = rs_ptr_r;
    assign o_context_stack_pointer = cs_ptr_r;

endmodule

`default_nettype wire

// ### verilog/nvi_pkg.sv
// Constants and types of the nested vectored interrupt unit
package nvi_pkg;

    // Program counter, stack and identifier sizes
    localparam int PC_W       = 13;
    localparam int RS_DEPTH   = 16;
    localparam int RS_PTR_W   = 4;
    localparam int CS_DEPTH   = 4;
    localparam int CS_PTR_W   = 2;
    localparam int N_ID       = 4;
    localparam int ID_W       = 2;

    // Context field widths: carry, G-register, selection, data
    localparam int G_W        = 16;
    localparam int SEL_W      = 5;
    localparam int DATA_W     = 4;
    localparam int CTX_W      = 1 + G_W + SEL_W + DATA_W;

    // Reset values
    localparam logic [RS_PTR_W-1:0] RS_PTR_RST = 4'h0;
    localparam logic [CS_PTR_W-1:0] CS_PTR_RST = 2'h0;
    localparam logic                MASTER_RST = 1'b0;
    localparam logic [N_ID-1:0]     LATCH_RST  = 4'h0;
    localparam logic [N_ID-1:0]     ISR_RST    = 4'h0;

    // Vector per identifier, index = identifier
    localparam logic [N_ID-1:0][PC_W-1:0] VEC_TABLE = {13'h0004, 13'h0003, 13'h0002, 13'h0001};

    // Reset priority: slot k holds identifier k, slot 0 most urgent
    localparam logic [N_ID-1:0][ID_W-1:0] PRIO_RST = {2'h3, 2'h2, 2'h1, 2'h0};

    // Edge select bit positions for the external pins
    localparam int EDGE_RISE_BIT = 0;
    localparam int EDGE_FALL_BIT = 1;

    // Source selection codes for identifiers 1 and 2
    localparam logic       SRC1_PIN_B  = 1'b0;
    localparam logic       SRC1_TPORT  = 1'b1;
    localparam logic [1:0] SRC2_SERIAL = 2'h0;
    localparam logic [1:0] SRC2_TPORT  = 2'h1;
    localparam logic [1:0] SRC2_LOWV   = 2'h2;

    // Context saved on entry and restored on return
    typedef struct packed {
        logic              carry_flag;
        logic [G_W-1:0]    g_reg;
        logic [SEL_W-1:0]  data_sel;
        logic [DATA_W-1:0] data_reg;
    } nvi_ctx_s;

    // Priority table: lvl_id[k] is the identifier holding level k+1
    typedef struct packed {
        logic [N_ID-1:0][ID_W-1:0] lvl_id;
    } nvi_prio_s;

    // Sequencer states, Gray step from idle to either action
    typedef enum logic [1:0] {
        NVI_IDLE   = 2'b00,
        NVI_ENTER  = 2'b01,
        NVI_RETURN = 2'b10
    } nvi_state_e;

endpackage

// ### verilog/nvi_stack_mem.sv
// Small stack memory with one write port and a registered read port
`timescale 1ns/1ps
`default_nettype none

module nvi_stack_mem #(
    parameter int W  = 13,
    parameter int D  = 16,
    parameter int AW = 4
) (
    // Clock
    input  wire logic          i_clk,
    // Write port
    input  wire logic          i_we,
    input  wire logic [AW-1:0] i_waddr,
    input  wire logic [W-1:0]  i_wdata,
    // Read port
    input  wire logic          i_re,
    input  wire logic [AW-1:0] i_raddr,
    output logic      [W-1:0]  o_rdata
);

    logic [W-1:0] mem [D];

    // Storage has no reset; software owns the contents
    always_ff @(posedge i_clk) begin
        if (i_we) begin
            mem[i_waddr] <= i_wdata;
        end
        if (i_re) begin
            o_rdata <= mem[i_raddr];
        end
    end

endmodule

`default_nettype wire

// ### verilog/nvi_pin_edge.sv
// External request pin synchroniser and selectable edge detector
`timescale 1ns/1ps
`default_nettype none

module nvi_pin_edge (
    // Clock and reset
    input  wire logic       i_clk,
    input  wire logic       i_rst,
    // Pin and edge choice
    input  wire logic       i_pin,
    input  wire logic [1:0] i_edge_sel,
    // Request pulse
    output logic            o_req
);
    import nvi_pkg::*;

    logic sync1_r;
    logic sync2_r;
    logic prev_r;
    logic req_nxt;

    // Edge test reads only settled samples
    always_comb begin
        req_nxt = (i_edge_sel[EDGE_RISE_BIT] & sync2_r & ~prev_r)
                | (i_edge_sel[EDGE_FALL_BIT] & ~sync2_r & prev_r);
    end

    // Two-stage synchroniser, then history for edge detection
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            sync1_r <= 1'b0;
            sync2_r <= 1'b0;
            prev_r  <= 1'b0;
            o_req   <= 1'b0;
        end else begin
            sync1_r <= i_pin;
            sync2_r <= sync1_r;
            prev_r  <= sync2_r;
            o_req   <= req_nxt;
        end
    end

endmodule

`default_nettype wire

// ### tb/nvi_core_sva.sv
// Checker for interrupt entry, return and masking timing
`timescale 1ns/1ps
`default_nettype none
module nvi_core_sva (
    // Clock and reset
    input wire logic               i_clk,
    input wire logic               i_rst,
    // Inputs of interest
    input wire logic               i_master_irq_on_instr,
    input wire logic               i_master_irq_off_instr,
    input wire logic [3:0]         i_irq_enable,
    input wire logic               i_return_from_irq_instr,
    // Outputs watched
    input wire logic               o_master_en,
    input wire nvi_pkg::nvi_prio_s o_prio,
    input wire logic               o_entry,
    input wire logic               o_return,
    input wire logic [12:0]        o_pc_load,
    input wire logic [1:0]         o_active_id,
    input wire logic [3:0]         o_in_service,
    input wire logic [3:0]         o_return_stack_pointer,
    input wire logic [1:0]         o_context_stack_pointer
);
    import nvi_pkg::*;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    logic [1:0] lvl;
    logic [3:0] upto_mask;
    logic [3:0] en_d;
    // Level slot of the identifier just accepted
    always_comb begin
        lvl = 2'h0;
        for (int k = 0; k < N_ID; k++) begin
            if (o_prio.lvl_id[k] == o_active_id) lvl = 2'(k);
        end
    end
    // Levels as urgent as the accepted one or more
    assign upto_mask = (4'h2 << lvl) - 4'h1;
    // Enables as they stood at the accepting edge
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) en_d <= 4'h0;
        else en_d <= i_irq_enable;
    end
    // Return request in an idle cycle, then a one-cycle answer
    sequence s_ret_req;
        i_return_from_irq_instr && !o_entry && !o_return;
    endsequence
    sequence s_ret_ans;
        o_return ##1 !o_return;
    endsequence
    entry_vector_a: assert property (o_entry |-> o_pc_load == VEC_TABLE[o_active_id])
        else $error("entry vector wrong");
    entry_ptr_dec_a: assert property (o_entry |->
        o_return_stack_pointer == $past(o_return_stack_pointer) - 4'h1 &&
        o_context_stack_pointer == $past(o_context_stack_pointer) - 2'h1)
        else $error("entry pointers not decremented");
    ret_ptr_inc_a: assert property (o_return |->
        o_return_stack_pointer == $past(o_return_stack_pointer) + 4'h1 &&
        o_context_stack_pointer == $past(o_context_stack_pointer) + 2'h1)
        else $error("return pointers not incremented");
    entry_pulse_a: assert property (o_entry |=> !o_entry && !o_return)
        else $error("entry longer than one cycle");
    ret_one_cycle_a: assert property (s_ret_req |=> s_ret_ans)
        else $error("return not done in one cycle");
    master_gate_a: assert property (!o_master_en |=> !o_entry)
        else $error("entry while master off");
    enable_gate_a: assert property (o_entry |-> en_d[o_active_id])
        else $error("entry of disabled source");
    nest_order_a: assert property (o_entry |->
        ($past(o_in_service) & upto_mask) == 4'h0 && o_in_service[lvl])
        else $error("entry not more urgent than service");
    ret_unmask_a: assert property (o_return |->
        o_in_service == ($past(o_in_service) & ($past(o_in_service) - 4'h1)))
        else $error("return cleared wrong level");
    master_hold_a: assert property
        (!i_master_irq_on_instr && !i_master_irq_off_instr |=> $stable(o_master_en))
        else $error("master flag moved without instruction");
endmodule
bind nvi_core nvi_core_sva u_sva (.i_clk, .i_rst, .i_master_irq_on_instr,
    .i_master_irq_off_instr, .i_irq_enable, .i_return_from_irq_instr, .o_master_en,
    .o_prio, .o_entry, .o_return, .o_pc_load, .o_active_id, .o_in_service,
    .o_return_stack_pointer, .o_context_stack_pointer);
`default_nettype wire

// ### tb/nvi_core_partner.sv
// Behavioural core sequencer facing the interrupt unit
`timescale 1ns/1ps
`default_nettype none
module nvi_core_partner (
    // Clock and reset
    input  wire logic              i_clk,
    input  wire logic              i_rst,
    // Unit outputs seen by the core
    input  wire logic              i_entry,
    input  wire logic              i_return,
    input  wire logic [12:0]       i_pc_load,
    input  wire nvi_pkg::nvi_ctx_s i_ctx,
    // Core state offered to the unit
    output logic                   o_boundary,
    output logic [12:0]            o_pc_next,
    output nvi_pkg::nvi_ctx_s      o_ctx,
    // Result counts
    output int                     o_fails,
    output int                     o_checks
);
    import nvi_pkg::*;
    logic [12:0] pc_r;
    logic [12:0] saved_q[$];
    // Free-running address so each accept saves a fresh value
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) pc_r <= 13'h0100;
        else pc_r <= pc_r + 13'h0001;
    end
    // Boundary withheld one cycle in four, so some accepts are deferred
    assign o_boundary = (pc_r[1:0] != 2'h3);
    assign o_pc_next  = pc_r;
    assign o_ctx      = nvi_ctx_s'({pc_r, ~pc_r});
    // Own stack of what the unit should hand back
    always @(posedge i_clk) begin
        if (i_rst) begin
            o_fails = 0;
            o_checks = 0;
            saved_q.delete();
        end else begin
            // address sampled at the accepting edge
            if (i_entry) saved_q.push_back(pc_r - 13'h0001);
            if (i_return && saved_q.size() > 0) begin
                o_checks++;
                if ({i_pc_load, i_ctx} !== {saved_q[$], saved_q[$], ~saved_q[$]}) begin
                    o_fails++;
                    $display("unexpected return: expected %h seen %h", saved_q[$], i_pc_load);
                end
                saved_q.pop_back();
            end
        end
    end
endmodule
`default_nettype wire

// ### tb/tb.sv
// Self-checking bench for the nested vectored interrupt unit
`timescale 1ns/1ps
`default_nettype none
module tb;
    import nvi_pkg::*;
    logic       i_clk = 1'b0;
    logic       i_rst = 1'b1;
    logic       i_ext_request_pin_a, i_ext_request_pin_b, i_src1_sel, i_prio_wr;
    logic       i_timer_port_req, i_serial_req, i_lowvolt_req, i_timer_cnt_req;
    logic       i_master_irq_on_instr, i_master_irq_off_instr, i_return_from_irq_instr;
    logic       i_boundary, o_master_en, o_entry, o_return;
    logic [1:0] i_edge_sel_a, i_edge_sel_b, i_src2_sel, o_active_id, o_context_stack_pointer;
    logic [3:0] i_irq_enable, i_latch_clr, o_latch, o_in_service, o_return_stack_pointer;
    logic [12:0] i_pc_next, o_pc_load;
    nvi_prio_s  i_prio_data, o_prio;
    nvi_ctx_s   i_ctx, o_ctx;
    int         n_fail, compares, p_fails, p_checks, cycles;

    nvi_core dut (.*);
    nvi_core_partner u_core (.i_clk, .i_rst, .i_entry(o_entry), .i_return(o_return),
        .i_pc_load(o_pc_load), .i_ctx(o_ctx), .o_boundary(i_boundary), .o_pc_next(i_pc_next),
        .o_ctx(i_ctx), .o_fails(p_fails), .o_checks(p_checks));

    ////////////////////////////////////////////////////////////////////////
    // Clock and hang guard
    always #12.5 i_clk = ~i_clk;
    always @(posedge i_clk) begin
        cycles++;
        if (cycles == 3000) begin
            n_fail++;
            summarize();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic tick(input int n = 1);
        repeat (n) @(posedge i_clk);
        #2;
    endtask
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic pulse_req(input logic [3:0] r);
        {i_timer_cnt_req, i_lowvolt_req, i_serial_req, i_timer_port_req} = r;
        tick();
        {i_timer_cnt_req, i_lowvolt_req, i_serial_req, i_timer_port_req} = 4'h0;
    endtask
    task automatic clr();
        i_latch_clr = 4'hF;
        tick();
        i_latch_clr = 4'h0;
    endtask
    task automatic ptrs(input logic [3:0] rs, input logic [1:0] cs);
        check("pointers", 32'({rs, cs}), 32'({o_return_stack_pointer, o_context_stack_pointer}));
    endtask
    // Bounded wait for entry, then its vector
    task automatic await_entry(input logic [12:0] vec);
        int n;
        n = 0;
        while (o_entry !== 1'b1 && n < 12) begin
            tick();
            n++;
        end
        check("entry vector", 32'({1'b1, vec}), 32'({o_entry, o_pc_load}));
    endtask
    // Legal exit, one idle cycle after any entry
    task automatic do_return();
        tick();
        i_return_from_irq_instr = 1'b1;
        tick();
        i_return_from_irq_instr = 1'b0;
        check("return pulse", 32'h1, 32'(o_return));
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Each source choice with master off, then cleared
    task automatic t_latch_src();
        logic [10:0] tab [6] = '{11'h712, 11'h024, 11'h114, 11'h244, 11'h440, 11'h388};
        i_irq_enable = 4'hF;
        foreach (tab[i]) begin
            {i_src1_sel, i_src2_sel} = tab[i][10:8];
            clr();
            pulse_req(tab[i][7:4]);
            tick(3);
            check("latch by source", 32'(tab[i][3:0]), 32'(o_latch));
            clr();
            check("latch cleared", 32'h0, 32'(o_latch));
        end
    endtask
    // Nesting two deep, same level refused, unmask on return
    task automatic t_nest();
        i_src2_sel = 2'h2;
        clr();
        i_master_irq_on_instr = 1'b1;
        tick();
        i_master_irq_on_instr = 1'b0;
        check("master on", 32'h1, 32'(o_master_en));
        pulse_req(4'h8);
        await_entry(13'h0004);
        check("latch taken", 32'h0, 32'(o_latch));
        ptrs(4'hF, 2'h3);
        tick();
        pulse_req(4'hC);
        await_entry(13'h0003);
        ptrs(4'hE, 2'h2);
        tick(4);
        check("same level held", 32'h8, 32'(o_latch));
        do_return();
        ptrs(4'hF, 2'h3);
        tick(4);
        check("same level refused", 32'h8, 32'(o_latch));
        do_return();
        await_entry(13'h0004);
        do_return();
        ptrs(4'h0, 2'h0);
        check("master kept", 32'h1, 32'(o_master_en));
    endtask
    // Chosen pin edge latches, the other not
    task automatic t_pin();
        i_irq_enable = 4'h0;
        i_edge_sel_a = 2'h1;
        i_ext_request_pin_a = 1'b1;
        tick(6);
        check("rising latched", 32'h1, 32'(o_latch));
        i_irq_enable = 4'h1;
        await_entry(13'h0001);
        do_return();
        i_ext_request_pin_a = 1'b0;
        tick(6);
        check("falling ignored", 32'h0, 32'(o_latch));
        i_master_irq_off_instr = 1'b1;
        tick();
        i_master_irq_off_instr = 1'b0;
        check("master off", 32'h0, 32'(o_master_en));
        i_src1_sel = 1'b0;
        i_edge_sel_b = 2'h3;
        i_ext_request_pin_b = 1'b1;
        tick(6);
        check("pin b rising", 32'h2, 32'(o_latch));
        clr();
        i_ext_request_pin_b = 1'b0;
        tick(6);
        check("pin b falling", 32'h2, 32'(o_latch));
        i_prio_data = 8'h1B;
        {i_prio_wr, i_master_irq_on_instr, i_irq_enable} = 6'h3F;
        pulse_req(4'h8);
        {i_prio_wr, i_master_irq_on_instr} = 2'h0;
        check("priority set", 32'h1B, 32'(o_prio));
        await_entry(13'h0004);
        check("others held", 32'h2, 32'(o_latch));
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic summarize();
        n_fail = n_fail + p_fails;
        compares = compares + p_checks;
        $display("compares %0d mismatches %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    initial begin
        n_fail = 0;
        compares = 0;
        cycles = 0;
        {i_ext_request_pin_a, i_ext_request_pin_b, i_edge_sel_a, i_edge_sel_b, i_timer_port_req,
         i_serial_req, i_lowvolt_req, i_timer_cnt_req, i_src1_sel, i_src2_sel, i_irq_enable,
         i_master_irq_on_instr, i_master_irq_off_instr, i_latch_clr, i_prio_wr, i_prio_data,
         i_return_from_irq_instr} = '0;
        tick(20);
        i_rst = 1'b0;
        tick(2);
        check("priority", 32'h0000_00E4, 32'(o_prio));
        check("latch master", 32'h0, 32'({o_latch, o_master_en}));
        ptrs(4'h0, 2'h0);
        t_latch_src();
        t_nest();
        t_pin();
        summarize();
    end
endmodule
`default_nettype wire
